/* hw/fra_pkg.sv */
`default_nettype none
package fra_pkg;
  // ------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] A_ASZ = 8'h00;
  localparam logic [7:0] A_RWT = 8'h04;
  localparam logic [7:0] A_BFC = 8'h08;
  localparam int BE_BIT = 0;
  localparam int BS_BIT = 1;
  // Access size codes
  localparam logic [1:0] ASZ_PROG = 2'h1;
  localparam logic [1:0] ASZ_ROM = 2'h2;
  // Read wait codes
  localparam logic [1:0] RWT_DIRECT = 2'h0;
  localparam logic [1:0] RWT_BAD = 2'h1;
  localparam logic [1:0] RWT_ACC0 = 2'h2;
  localparam logic [1:0] RWT_ACC1 = 2'h3;
  // Reset values
  localparam logic [1:0] ASZ_RST = ASZ_ROM;
  localparam logic [1:0] RWT_RST = RWT_ACC1;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int HCLK_MAX_MHZ = 160;
  localparam logic [10:0] TB_INIT_CYC = 11'h401;
  // Wait cycles of a flash access without trace probe
  localparam logic [2:0] FLW_ACC0 = 3'h3;
  localparam logic [2:0] FLW_ACC1 = 3'h4;
  localparam logic [2:0] FLW_DIRECT = 3'h2;
  // Lookup sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_TB = 3'b001,
    S_FL = 3'b010,
    S_RET = 3'b011,
    S_PF = 3'b100
  } fra_state_t;
endpackage : fra_pkg
`default_nettype wire

/* hw/fra_top.sv */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Prefetch and data buffer hits answer with zero wait up to 160 MHz
// - Four 128-bit prefetch lines; a hit answers with no wait
// - 16 KB trace buffer records every line read from flash in an accelerator mode
// - Trace buffer hit answers the recorded value after one wait
// - Mode zero: prefetch miss costs one cycle, then trace lookup
// - Trace miss starts a flash access, 4 or 5 waits in total
// - Miss in both buffers: flash access adds 3 or 4 waits
// - Trace buffer off: no trace lookup, 3 or 4 waits
// - Mode one: same flow, different wait counts
// - Reset: accelerator mode one, prefetch on, trace off
// - Two 128-bit data buffer entries for data bus reads
// - Data buffer only in ROM mode and an accelerator mode
// - Data buffer keeps two newest reads, hit has no wait
// - Writing access size or read wait clears data buffer
// - Each data entry is one aligned 128-bit block
// - Trace enable starts 1025 cycles of init, then status set
// - Prefetch keeps serving reads during trace init
// - Programming mode clears trace enable and status
// - Read wait codes 00, 10, 11; code 01 refused
module fra_top #(
  parameter int AW = 32,
  parameter int PF_LINES = 4,
  parameter int TB_LINES = 1024
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // APB register port
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Instruction fetch port
  input wire logic IF_REQ_IN,
  input wire logic [AW-1:0] IF_ADDR_IN,
  output logic IF_RDY_OUT,
  output logic IF_HIT_OUT,
  output logic [31:0] IF_DATA_OUT,
  // Data read port
  input wire logic D_REQ_IN,
  input wire logic [AW-1:0] D_ADDR_IN,
  output logic D_RDY_OUT,
  output logic [31:0] D_DATA_OUT,
  // Flash array port
  output logic FL_REQ_OUT,
  output logic [AW-5:0] FL_LINE_OUT,
  input wire logic [127:0] FL_RDATA_IN
);
  import fra_pkg::*;
  localparam int LW = AW - 4;
  localparam int TI = $clog2(TB_LINES);
  localparam int PI = $clog2(PF_LINES);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [1:0] asz_reg, rwt_reg;
  logic be_reg, bs_reg;
  logic [10:0] init_reg;
  logic [31:0] rdata_reg;
  fra_state_t st_reg, st_next;
  logic who_reg;
  logic [LW-1:0] line_reg, pfn_reg;
  logic [2:0] cnt_reg;
  logic [127:0] ret_reg;
  logic [LW-1:0] pf_tag [PF_LINES];
  logic [127:0] pf_dat [PF_LINES];
  logic [PF_LINES-1:0] pfv_reg;
  logic [PI-1:0] pfp_reg;
  logic [LW-TI-1:0] tb_tag [TB_LINES];
  logic [127:0] tb_dat [TB_LINES];
  logic [TB_LINES-1:0] tbv_reg;
  logic [LW-1:0] db_tag [2];
  logic [127:0] db_dat [2];
  logic [1:0] dbv_reg;
  logic dbo_reg;

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  // APB strobes and address decode
  wire apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire sel_asz = PADDR_IN == A_ASZ;
  wire sel_rwt = PADDR_IN == A_RWT;
  wire sel_bfc = PADDR_IN == A_BFC;
  wire map_ok = sel_asz | sel_rwt | sel_bfc;
  wire wr_asz = apb_wr & sel_asz;
  wire wr_rwt = apb_wr & sel_rwt;
  wire wr_bfc = apb_wr & sel_bfc;
  wire [1:0] wv = PWDATA_IN[1:0];
  wire asz_ok = (wv == ASZ_PROG) | (wv == ASZ_ROM);
  wire [31:0] rd_mux = sel_asz ? {30'h0, asz_reg} :
                       sel_rwt ? {30'h0, rwt_reg} :
                       sel_bfc ? {30'h0, bs_reg, be_reg} : 32'h0;
  // Mode terms
  wire acc = rwt_reg[1];
  wire rom = asz_reg == ASZ_ROM;
  wire prog = asz_reg == ASZ_PROG;
  wire tb_on = bs_reg & acc & rom;
  wire db_en = rom & acc;
  wire [2:0] flw = (rwt_reg == RWT_ACC1) ? FLW_ACC1 :
                   (rwt_reg == RWT_ACC0) ? FLW_ACC0 : FLW_DIRECT;
  wire [LW-1:0] f_line = IF_ADDR_IN[AW-1:4];
  wire [LW-1:0] d_line = D_ADDR_IN[AW-1:4];

  // Prefetch lookups for the fetch and for the next line
  logic [PF_LINES-1:0] pfh, pfn;
  logic [127:0] pf_line;
  for (genvar i = 0; i < PF_LINES; i++) begin : g_pf
    assign pfh[i] = pfv_reg[i] & (pf_tag[i] == f_line);
    assign pfn[i] = pfv_reg[i] & (pf_tag[i] == pfn_reg);
  end
  always_comb begin
    pf_line = '0;
    for (int i = 0; i < PF_LINES; i++) begin
      if (pfh[i]) begin
        pf_line = pf_dat[i];
      end
    end
  end
  // prefetch does not depend on trace status
  wire pf_ok = acc & |pfh;

  // trace lookup on the held line
  wire [TI-1:0] ti_w = line_reg[TI-1:0];
  wire tb_hit = tb_on & tbv_reg[ti_w] & (tb_tag[ti_w] == line_reg[LW-1:TI]);

  wire [1:0] dbh = {dbv_reg[1] & (db_tag[1] == d_line),
                    dbv_reg[0] & (db_tag[0] == d_line)};
  wire db_ok = db_en & |dbh;
  wire [127:0] db_line = dbh[1] ? db_dat[1] : db_dat[0];

  // Sequencer terms
  wire f_miss = IF_REQ_IN & ~pf_ok;
  wire d_miss = D_REQ_IN & ~db_ok;
  wire fl_end = cnt_reg == 3'h0;
  wire fill = ((st_reg == S_FL) | (st_reg == S_PF)) & fl_end;
  wire pf_fill = fill & ((st_reg == S_PF) | ~who_reg);
  wire db_fill = (st_reg == S_FL) & fl_end & who_reg & db_en;
  // every flash line goes to the trace buffer while tb_on is set (trace on, ROM and accelerator mode)
  wire tb_fill = fill & tb_on;
  wire pf_want = acc & rom & ~|pfn & ~IF_REQ_IN & ~D_REQ_IN;

  function automatic logic [31:0] wsel(input logic [127:0] l,
                                       input logic [1:0] s);
    wsel = l[{s, 5'h00} +: 32];
  endfunction : wsel

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Control registers; refused codes leave the field unchanged
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      asz_reg <= ASZ_RST;
      rwt_reg <= RWT_RST;
      be_reg <= 1'b0;
      bs_reg <= 1'b0;
      init_reg <= 11'h000;
    end else begin
      if (wr_asz & asz_ok) begin
        asz_reg <= wv;
      end
      if (wr_rwt & (wv != RWT_BAD)) begin
        rwt_reg <= wv;
      end
      if (wr_asz & (wv == ASZ_PROG)) begin
        be_reg <= 1'b0;
        bs_reg <= 1'b0;
      end else if (wr_bfc) begin
        be_reg <= PWDATA_IN[BE_BIT] & ~prog;
        if (~PWDATA_IN[BE_BIT] | ~be_reg) begin
          bs_reg <= 1'b0;
          init_reg <= 11'h000;
        end
      end else if (be_reg & ~bs_reg) begin
        init_reg <= init_reg + 11'h001;
        if (init_reg == TB_INIT_CYC - 11'h001) begin
          bs_reg <= 1'b1;
        end
      end
    end
  end

  // Read data is caught in the setup phase so it comes from a flop
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      rdata_reg <= 32'h0;
    end else if (PSEL_IN & ~PENABLE_IN) begin
      rdata_reg <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Lookup sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      S_IDLE: begin
        if (f_miss) begin
          st_next = tb_on ? S_TB : S_FL;
        end else if (d_miss) begin
          st_next = S_FL;
        end else if (pf_want) begin
          st_next = S_PF;
        end
      end
      S_TB: st_next = tb_hit ? S_IDLE : S_FL;
      S_FL: if (fl_end) st_next = S_RET;
      S_RET: st_next = S_IDLE;
      // A demand aborts a prefetch so it waits only one cycle more
      S_PF: if (fl_end | IF_REQ_IN | D_REQ_IN) st_next = S_IDLE;
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      st_reg <= S_IDLE;
      who_reg <= 1'b0;
      line_reg <= '0;
      cnt_reg <= 3'h0;
      ret_reg <= '0;
      pfn_reg <= '0;
    end else begin
      st_reg <= st_next;
      if (st_reg == S_IDLE) begin
        who_reg <= ~f_miss;
        line_reg <= f_miss ? f_line : (d_miss ? d_line : pfn_reg);
      end
      if ((st_reg == S_IDLE) | (st_reg == S_TB)) begin
        cnt_reg <= flw - 3'h2;
      end else if (!fl_end) begin
        cnt_reg <= cnt_reg - 3'h1;
      end
      if ((st_reg == S_FL) & fl_end) begin
        ret_reg <= FL_RDATA_IN;
      end
      // next line follows the last fetch
      if (IF_RDY_OUT) begin
        pfn_reg <= f_line + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Buffers
  // ------------------------------------------------------------
  // prefetch slots filled in turn, oldest replaced
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN | wr_asz | wr_rwt) begin
      pfv_reg <= '0;
      pfp_reg <= '0;
    end else if (pf_fill) begin
      pfv_reg[pfp_reg] <= 1'b1;
      pf_tag[pfp_reg] <= line_reg;
      pf_dat[pfp_reg] <= FL_RDATA_IN;
      pfp_reg <= pfp_reg + 1'b1;
    end
  end

  // init clears one valid bit per cycle
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      tbv_reg <= '0;
    end else if (be_reg & ~bs_reg) begin
      if (init_reg < TB_LINES) begin
        tbv_reg[init_reg[TI-1:0]] <= 1'b0;
      end
    end else if (tb_fill) begin
      tbv_reg[ti_w] <= 1'b1;
      tb_tag[ti_w] <= line_reg[LW-1:TI];
      tb_dat[ti_w] <= FL_RDATA_IN;
    end
  end

  // Data buffer; invalid entries are used before the older one
  wire db_slot = ~dbv_reg[0] ? 1'b0 : (~dbv_reg[1] ? 1'b1 : dbo_reg);
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN | wr_asz | wr_rwt) begin
      dbv_reg <= 2'h0;
      dbo_reg <= 1'b0;
    end else if (db_fill) begin
      dbv_reg[db_slot] <= 1'b1;
      db_tag[db_slot] <= line_reg;
      db_dat[db_slot] <= FL_RDATA_IN;
      dbo_reg <= ~db_slot;
    end else if (D_RDY_OUT & (st_reg == S_IDLE)) begin
      dbo_reg <= ~dbh[1];
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // prefetch hits answer in the request cycle, trace hits one cycle later
  assign IF_RDY_OUT = IF_REQ_IN & (((st_reg == S_IDLE) & pf_ok) |
                      ((st_reg == S_TB) & tb_hit) |
                      ((st_reg == S_RET) & ~who_reg));
  assign IF_HIT_OUT = IF_RDY_OUT & (st_reg != S_RET);
  assign IF_DATA_OUT = wsel((st_reg == S_RET) ? ret_reg :
                            (st_reg == S_TB) ? tb_dat[ti_w] : pf_line,
                            IF_ADDR_IN[3:2]);
  // data port served from two entries or from the returned flash line
  assign D_RDY_OUT = D_REQ_IN & (((st_reg == S_IDLE) & db_ok) |
                     ((st_reg == S_RET) & who_reg));
  assign D_DATA_OUT = wsel((st_reg == S_RET) ? ret_reg : db_line,
                           D_ADDR_IN[3:2]);
  assign FL_REQ_OUT = (st_reg == S_FL) | (st_reg == S_PF);
  assign FL_LINE_OUT = line_reg;
  assign PRDATA_OUT = rdata_reg;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~map_ok;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [10:0] h_init;
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN | wr_bfc) begin
      h_init <= 11'h000;
    end else if (be_reg & ~bs_reg) begin
      h_init <= h_init + 11'h001;
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);

  property p_rst;
    $fell(SRST_IN) |-> rwt_reg == RWT_ACC1 && !be_reg && !bs_reg;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset mode");
  property p_pfhit;
    st_reg == S_IDLE && IF_REQ_IN && pf_ok |-> IF_RDY_OUT && IF_HIT_OUT;
  endproperty
  a_pfhit: assert property (p_pfhit) else $error("pf hit waited");
  property p_probe;
    st_reg == S_IDLE && IF_REQ_IN && !pf_ok && tb_on
      |-> !IF_RDY_OUT ##1 st_reg == S_TB;
  endproperty
  a_probe: assert property (p_probe) else $error("no probe");
  property p_tbhit;
    st_reg == S_TB && tb_hit && IF_REQ_IN |-> IF_RDY_OUT ##1 st_reg == S_IDLE;
  endproperty
  a_tbhit: assert property (p_tbhit) else $error("tb hit waited");
  property p_tbmiss;
    st_reg == S_TB && !tb_hit && IF_REQ_IN && rwt_reg == RWT_ACC0
      |-> !IF_RDY_OUT [*3] ##1 IF_RDY_OUT;
  endproperty
  a_tbmiss: assert property (p_tbmiss) else $error("tb miss wait");
  property p_nomiss;
    st_reg == S_IDLE && f_miss && !tb_on && rwt_reg == RWT_ACC0
      |-> !IF_RDY_OUT [*3] ##1 IF_RDY_OUT;
  endproperty
  a_nomiss: assert property (p_nomiss) else $error("miss wait");
  property p_acc1;
    st_reg == S_IDLE && f_miss && !tb_on && rwt_reg == RWT_ACC1
      |-> !IF_RDY_OUT [*4] ##1 IF_RDY_OUT;
  endproperty
  a_acc1: assert property (p_acc1) else $error("mode one wait");
  property p_init;
    $rose(bs_reg) |-> h_init == 11'd1025 && be_reg;
  endproperty
  a_init: assert property (p_init) else $error("init length");
  property p_prog;
    wr_asz && wv == ASZ_PROG |=> !be_reg && !bs_reg;
  endproperty
  a_prog: assert property (p_prog) else $error("trace kept");
  property p_dinv;
    wr_asz || wr_rwt |=> dbv_reg == 2'h0;
  endproperty
  a_dinv: assert property (p_dinv) else $error("dbuf kept");
  property p_dben;
    st_reg == S_IDLE && D_REQ_IN && !db_en |-> !D_RDY_OUT;
  endproperty
  a_dben: assert property (p_dben) else $error("dbuf used");
  property p_rwt;
    rwt_reg != RWT_BAD;
  endproperty
  a_rwt: assert property (p_rwt) else $error("bad read wait");
  c_pfhit: cover property (IF_HIT_OUT && st_reg == S_IDLE);
  c_tbhit: cover property (IF_HIT_OUT && st_reg == S_TB);
  c_dbhit: cover property (D_RDY_OUT && st_reg == S_IDLE);
  c_init: cover property ($rose(bs_reg));
endmodule : fra_top
`default_nettype wire

/* verification/fra_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fra_flash_model (
  // Clock
  input wire logic clk_in,
  // Line request from the accelerator
  input wire logic req_in,
  input wire logic [27:0] line_in,
  // Line data back
  output logic [127:0] rdata_out
);
  logic [127:0] junk_reg = 128'h0;
  logic [127:0] line_data;
  // Each word carries its own address, masked, so misrouting shows up
  always_comb begin
    for (int w = 0; w < 4; w++) begin
      line_data[32*w +: 32] = {line_in, w[1:0], 2'h0} ^ 32'hA5C3_0F96;
    end
  end
  // Released bus toggles, so stale data can never pass for a fresh line
  always @(posedge clk_in) begin
    junk_reg <= ~junk_reg;
  end
  assign rdata_out = req_in ? line_data : junk_reg;
endmodule : fra_flash_model
`default_nettype wire

/* verification/flash_read_accelerator_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_read_accelerator_tb_top;
  import fra_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, observed outputs and reference state
  // ----------------------------------------------------------------
  logic clk = 1'b0, srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, if_data, d_data;
  logic pready, pslverr, if_rdy, if_hit, d_rdy, fl_req;
  logic if_req = 1'b0, d_req = 1'b0;
  logic [31:0] if_addr = 32'h0, d_addr = 32'h0;
  logic [27:0] fl_line;
  logic [127:0] fl_rdata;
  int error_cnt = 0, checked = 0, cyc = 0;
  logic [1:0] m_asz = 2'h2, m_rwt = 2'h3;
  bit m_bs = 1'b0;
  int pf_q[$], db_q[$];
  bit tr[int];

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  fra_top fra_top_i (
    .CLOCK_IN(clk), .SRST_IN(srst),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .IF_REQ_IN(if_req), .IF_ADDR_IN(if_addr), .IF_RDY_OUT(if_rdy),
    .IF_HIT_OUT(if_hit), .IF_DATA_OUT(if_data),
    .D_REQ_IN(d_req), .D_ADDR_IN(d_addr), .D_RDY_OUT(d_rdy),
    .D_DATA_OUT(d_data),
    .FL_REQ_OUT(fl_req), .FL_LINE_OUT(fl_line), .FL_RDATA_IN(fl_rdata)
  );
  fra_flash_model fra_flash_model_i (
    .clk_in(clk), .req_in(fl_req), .line_in(fl_line), .rdata_out(fl_rdata)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  function automatic bit in_q(input int q[$], input int v);
    foreach (q[i]) begin
      if (q[i] == v) return 1'b1;
    end
    return 1'b0;
  endfunction : in_q

  // ----------------------------------------------------------------
  // APB master: request held until pready is seen at an edge
  // ----------------------------------------------------------------
  task automatic apb(input logic wr_en, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd_d,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd_d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    if (a == A_ASZ && (d[1:0] == ASZ_PROG || d[1:0] == ASZ_ROM)) m_asz = d[1:0];
    if (a == A_RWT && d[1:0] != RWT_BAD) m_rwt = d[1:0];
    if (a == A_ASZ && d[1:0] == ASZ_PROG) m_bs = 1'b0;
    if (a == A_ASZ || a == A_RWT) begin
      pf_q.delete();
      db_q.delete();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, exp_err});
  endtask : rd

  // ----------------------------------------------------------------
  // One fetch or data read, compared with the reference model
  // ----------------------------------------------------------------
  task automatic access(input int l, input bit dp);
    int w, wt, ew, n;
    bit ton;
    logic rdy, hit;
    logic [31:0] got;
    w = $urandom_range(3);
    ton = m_bs && m_rwt[1] && (m_asz == 2'h2);
    n = 0;
    // Let a running prefetch finish; aborting one adds a wait
    // Sampled mid-cycle, where the flash request has settled
    repeat (3) @(posedge clk);
    @(negedge clk);
    while (fl_req === 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n >= 60) error_cnt++;
    @(posedge clk);
    if (dp) begin
      d_req <= 1'b1;
      d_addr <= {l[27:0], w[1:0], 2'h0};
    end else begin
      if_req <= 1'b1;
      if_addr <= {l[27:0], w[1:0], 2'h0};
    end
    wt = 0;
    do begin
      @(negedge clk);
      rdy = dp ? d_rdy : if_rdy;
      if (rdy !== 1'b1) wt++;
    end while (rdy !== 1'b1 && wt < 40);
    got = dp ? d_data : if_data;
    hit = if_hit;
    @(posedge clk);
    if_req <= 1'b0;
    d_req <= 1'b0;
    if (dp) begin
      ew = (m_rwt == 2'h2) ? 3 : ((m_rwt == 2'h3) ? 4 : 2);
      if (m_asz == 2'h2 && m_rwt[1] && in_q(db_q, l)) ew = 0;
    end else if (m_rwt == 2'h0) ew = 2;
    else if (in_q(pf_q, l)) ew = 0;
    else if (ton && tr.exists(l)) ew = 1;
    else ew = ((m_rwt == 2'h2) ? 3 : 4) + ton;
    check(wt, ew);
    check(got, {l[27:0], w[1:0], 2'h0} ^ 32'hA5C3_0F96);
    if (!dp) check(hit, ew < 2);
    // newest entry to the back, oldest falls out
    if (dp && m_asz == 2'h2 && m_rwt[1]) begin
      for (int i = 0; i < db_q.size(); i++) begin
        if (db_q[i] == l) db_q.delete(i);
      end
      db_q.push_back(l);
      if (db_q.size() > 2) db_q.pop_front();
    end
    // every fetch line read from flash in an accelerator mode is recorded
    if (!dp && m_rwt != 2'h0 && ew > 1) begin
      if (ton) tr[l] = 1'b1;
      pf_q.push_back(l);
    end
    // the next line is fetched ahead
    if (!dp && m_rwt != 2'h0 && !in_q(pf_q, l + 1)) begin
      if (ton) tr[l + 1] = 1'b1;
      pf_q.push_back(l + 1);
    end
    while (pf_q.size() > 4) pf_q.pop_front();
  endtask : access

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int b, t0;
    logic [1:0] modes[5];
    modes = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
    b = $urandom(26932);
    b = 256 + $urandom_range(4000);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(A_ASZ, 32'h2, 1'b0);
    rd(A_RWT, 32'h3, 1'b0);
    rd(A_BFC, 32'h0, 1'b0);
    rd(8'h0C, 32'h0, 1'b1);
    // Every read wait code, the refused one included
    foreach (modes[i]) begin
      wr(A_RWT, {30'h0, modes[i]});
      // read back after each config write
      rd(A_RWT, {30'h0, m_rwt}, 1'b0);
      b += 8;
      access(b, 1'b0);
      access(b, 1'b0);
      access(b + 1, 1'b0);
    end
    wr(A_RWT, 32'h2);
    wr(A_BFC, 32'h1);
    t0 = cyc;
    rd(A_BFC, 32'h1, 1'b0);
    b += 8;
    access(b, 1'b0);
    while (cyc - t0 < 1015) @(posedge clk);
    rd(A_BFC, 32'h1, 1'b0);
    repeat (10) @(posedge clk);
    m_bs = 1'b1;
    rd(A_BFC, 32'h3, 1'b0);
    b += 8;
    access(b, 1'b0);
    wr(A_RWT, 32'h2);
    access(b, 1'b0);
    wr(A_RWT, 32'h3);
    b += 8;
    access(b, 1'b0);
    // no low power request exists on this bench
    // no flash programming traffic is issued
    wr(A_ASZ, 32'h1);
    rd(A_BFC, 32'h0, 1'b0);
    wr(A_ASZ, 32'h0);
    rd(A_ASZ, 32'h1, 1'b0);
    b += 8;
    // programming mode: data reads only, no fetch
    access(b, 1'b1);
    access(b, 1'b1);
    wr(A_ASZ, 32'h2);
    // ROM mode: the bench never writes the array
    b += 8;
    access(b, 1'b1);
    access(b, 1'b1);
    access(b + 1, 1'b1);
    access(b + 2, 1'b1);
    access(b + 1, 1'b1);
    access(b, 1'b1);
    wr(A_RWT, 32'h3);
    access(b + 1, 1'b1);
    tally_and_finish();
  end

  // The run needs about 1400 cycles; cut a hang off well beyond that
  initial begin
    #(20 * 20000);
    error_cnt++;
    tally_and_finish();
  end
endmodule : flash_read_accelerator_tb_top
`default_nettype wire
